// File: spc_pkg.sv
// Constants and types for the serial port control and status block
package spc_pkg;
  localparam logic [7:0] SLAVE_OWN_ADDRESS_OFS = 8'h00_a9;
  localparam logic [7:0] SCTL_OFS = 8'h00_98;
  localparam logic [7:0] PCTL_OFS = 8'h00_87;
  localparam logic [7:0] SLAVE_OWN_ADDRESS_RST = 8'h00_00;
  localparam logic [7:0] SCTL_RST = 8'h00_00;
  localparam logic [7:0] BCAST_MASK_RST = 8'h00_00;
  localparam int B_TOP = 7;
  localparam int B_MLO = 6;
  localparam int B_MPE = 5;
  localparam int B_REN = 4;
  localparam int B_TB8 = 3;
  localparam int B_RB8 = 2;
  localparam int B_TI = 1;
  localparam int B_RI = 0;
  localparam int B_DBL = 7;
  localparam int B_FSEL = 6;
  localparam logic [7:0] DIV_M0 = 8'h00_0c;
  localparam logic [7:0] DIV_M0_X2 = 8'h00_06;
  localparam logic [7:0] DIV_M2 = 8'h00_40;
  localparam logic [7:0] DIV_M2_DBL = 8'h00_20;
  localparam logic [7:0] DIV_M2_X2 = 8'h00_20;
  localparam logic [7:0] DIV_M2_X2_DBL = 8'h00_10;
  localparam logic [3:0] BITS_8 = 4'h8;
  localparam logic [3:0] BITS_9 = 4'h9;
  typedef enum logic [1:0] {SPC_IDLE, SPC_DATA, SPC_STOP} spc_state_e;
endpackage

// File: spc_serial_port.sv
// Serial port control/status registers with a compact transmitter and receiver
`timescale 1ns/100ps
`default_nettype none
module spc_serial_port (
  input wire logic mclk,
  input wire logic rst_b,
  input wire logic [7:0] sfr_addr,
  input wire logic [7:0] sfr_wdata,
  input wire logic sfr_wr,
  output logic [7:0] sfr_rdata,
  input wire logic [7:0] tx_data,
  input wire logic tx_start,
  output logic [7:0] rx_data,
  input wire logic [7:0] addr_mask,
  input wire logic double_speed_option,
  input wire logic baud_tick,
  input wire logic rxd_in,
  output logic txd_out,
  output logic shift_clk_out
);
  import spc_pkg::*;
  logic [7:0] slave_own_address, sctl;
  logic framing_error_flag, framing_select, baud_doubling;
  logic [7:0] div_cnt, rdiv_cnt;
  logic [8:0] tx_sh, rx_sh;
  logic [3:0] tx_cnt, rx_cnt;
  logic rx_prev;
  spc_state_e tx_st, rx_st;
  wire mode_select_hi = sctl[B_TOP];
  wire mode_select_lo = sctl[B_MLO];
  wire multiproc_enable = sctl[B_MPE];
  wire tx_ninth_bit = sctl[B_TB8];
  wire [1:0] mode = {mode_select_hi, mode_select_lo};
  wire mode0 = (mode == 2'b00);
  wire nine = mode[1];
  wire wr_sctl = sfr_wr && (sfr_addr == SCTL_OFS);
  wire wr_pctl = sfr_wr && (sfr_addr == PCTL_OFS);
  wire wr_slave_own_address = sfr_wr && (sfr_addr == SLAVE_OWN_ADDRESS_OFS);
  // Fixed-rate divisor; modes 1 and 3 take the external timer tick
  wire [7:0] div_m2 = double_speed_option ? (baud_doubling ? DIV_M2_X2_DBL : DIV_M2_X2) :
                      (baud_doubling ? DIV_M2_DBL : DIV_M2);
  wire [7:0] div_sel = mode0 ? (double_speed_option ? DIV_M0_X2 : DIV_M0) : div_m2;
  // In modes 0 and 2 the receiver waits half a bit after starting so every later sample lands mid-bit; modes 1 and 3 follow baud_tick
  wire [7:0] div_half = {1'b0, div_sel[7:1]};
  wire fixed_rate = mode0 || (mode == 2'b10);
  wire tx_tick = fixed_rate ? (div_cnt == 8'h00_00) : baud_tick;
  wire rx_tick = fixed_rate ? (rdiv_cnt == 8'h00_00) : baud_tick;
  wire [3:0] nbits = nine ? BITS_9 : BITS_8;
  wire [7:0] given = slave_own_address & addr_mask;
  wire [7:0] bcast = slave_own_address | addr_mask;
  function automatic logic addr_hit(input logic [7:0] a, input logic [7:0] m,
                                    input logic [7:0] g, input logic [7:0] b);
    // Broadcast: zeros of the broadcast byte are don't-care, its ones must all be set
    addr_hit = (((a ^ g) & m) == 8'h00_00) || (((a ^ b) & b) == 8'h00_00);
  endfunction
  wire stop_ok = rxd_in;
  wire ninth_rx = nine ? rx_sh[8] : stop_ok;
  wire mp_on = multiproc_enable && !mode0;
  wire rx_hit = addr_hit(rx_sh[7:0], addr_mask, given, bcast);
  // Address filter: with multiprocessor on, only address frames that match raise done
  wire rx_accept = !mp_on || (ninth_rx && rx_hit) && (nine || stop_ok);
  // The start bit also waits in this state with a zero count; only the stop sample ends a frame
  wire rx_end = (rx_st == SPC_STOP) && rx_tick && !mode0 && (rx_cnt != 4'h0);
  wire rx_m0_end = (rx_st == SPC_DATA) && rx_tick && mode0 && (rx_cnt == BITS_8 - 4'h1);
  wire set_fe = rx_end && !stop_ok;
  wire set_ri = rx_m0_end || (rx_end && rx_accept);
  wire set_ti = (tx_st == SPC_DATA) && tx_tick && (tx_cnt == nbits - 4'h1);
  wire [7:0] top_bit = framing_select ? {7'h00, framing_error_flag} : {7'h00, mode_select_hi};
  wire [7:0] sctl_view = {top_bit[0], sctl[6:0]};
  wire [7:0] pctl_view = {baud_doubling, framing_select, 6'h00};
  assign sfr_rdata = (sfr_addr == SCTL_OFS) ? sctl_view :
                     (sfr_addr == PCTL_OFS) ? pctl_view :
                     (sfr_addr == SLAVE_OWN_ADDRESS_OFS) ? slave_own_address : 8'h00_00;
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      slave_own_address <= SLAVE_OWN_ADDRESS_RST;
      framing_select <= 1'b0;
      baud_doubling <= 1'b0;
    end else begin
      if (wr_slave_own_address) slave_own_address <= sfr_wdata;
      if (wr_pctl) begin
        baud_doubling <= sfr_wdata[B_DBL];
        framing_select <= sfr_wdata[B_FSEL];
      end
    end
  end
  // Set wins over a same-cycle software clear for all hardware flags
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      sctl <= SCTL_RST;
      framing_error_flag <= 1'b0;
    end else begin
      if (wr_sctl) begin
        sctl[6:0] <= sfr_wdata[6:0];
        if (!framing_select) sctl[B_TOP] <= sfr_wdata[B_TOP];
      end
      if (wr_sctl && framing_select) framing_error_flag <= sfr_wdata[B_TOP];
      if (set_fe && rx_st != SPC_IDLE) framing_error_flag <= 1'b1;
      if (set_ti) sctl[B_TI] <= 1'b1;
      if (set_ri) sctl[B_RI] <= 1'b1;
      if (rx_end && rx_accept) sctl[B_RB8] <= ninth_rx;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      div_cnt <= 8'h00_00;
      rdiv_cnt <= 8'h00_00;
    end else begin
      div_cnt <= (tx_st == SPC_IDLE || div_cnt == 8'h00_00) ? div_sel - 8'h00_01 : div_cnt - 8'h00_01;
      rdiv_cnt <= (rx_st == SPC_IDLE) ? div_half - 8'h00_01 :
                  (rdiv_cnt == 8'h00_00) ? div_sel - 8'h00_01 : rdiv_cnt - 8'h00_01;
    end
  end
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      tx_st <= SPC_IDLE;
      tx_sh <= 9'h1ff;
      tx_cnt <= 4'h0;
      txd_out <= 1'b1;
    end else begin
      case (tx_st)
        SPC_IDLE: if (tx_start) begin
          tx_sh <= {tx_ninth_bit, tx_data};
          tx_cnt <= 4'h0;
          txd_out <= mode0 ? tx_data[0] : 1'b0;
          tx_st <= mode0 ? SPC_DATA : SPC_STOP;
        end
        SPC_STOP: if (tx_tick) begin
          if (txd_out == 1'b0) begin
            txd_out <= tx_sh[0];
            tx_st <= SPC_DATA;
          end else tx_st <= SPC_IDLE;
        end
        SPC_DATA: if (tx_tick) begin
          tx_sh <= {1'b1, tx_sh[8:1]};
          tx_cnt <= tx_cnt + 4'h1;
          if (tx_cnt == nbits - 4'h1 || (mode0 && tx_cnt == BITS_8 - 4'h1)) begin
            txd_out <= 1'b1;
            tx_st <= mode0 ? SPC_IDLE : SPC_STOP;
          end else txd_out <= tx_sh[1];
        end
        default: tx_st <= SPC_IDLE;
      endcase
    end
  end
  assign shift_clk_out = mode0 && (tx_st == SPC_DATA) && (div_cnt < {1'b0, div_sel[7:1]});
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      rx_st <= SPC_IDLE;
      rx_sh <= 9'h000;
      rx_cnt <= 4'h0;
      rx_prev <= 1'b1;
      rx_data <= 8'h00_00;
    end else begin
      rx_prev <= rxd_in;
      case (rx_st)
        SPC_IDLE: if (sctl[B_REN] && (mode0 || (rx_prev && !rxd_in))) begin
          rx_cnt <= 4'h0;
          rx_st <= mode0 ? SPC_DATA : SPC_STOP;
        end
        SPC_STOP: if (rx_tick) begin
          if (rx_cnt == 4'h0) begin
            rx_st <= SPC_DATA;
          end else begin
            if (rx_accept) rx_data <= rx_sh[7:0];
            rx_st <= SPC_IDLE;
          end
        end
        SPC_DATA: if (rx_tick) begin
          rx_sh <= nine || mode0 ? {rxd_in, rx_sh[8:1]} : {1'b0, rxd_in, rx_sh[7:1]};
          rx_cnt <= rx_cnt + 4'h1;
          if (mode0 && rx_cnt == BITS_8 - 4'h1) begin
            rx_data <= {rxd_in, rx_sh[8:2]};
            rx_st <= SPC_IDLE;
          end else if (!mode0 && rx_cnt == nbits - 4'h1) rx_st <= SPC_STOP;
        end
        default: rx_st <= SPC_IDLE;
      endcase
    end
  end
  fe_sticky_a: assert property (@(posedge mclk) disable iff (!rst_b)
    framing_error_flag && !(wr_sctl && framing_select) |=> framing_error_flag)
    else $error("framing flag dropped without software");
  fe_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    set_fe && rx_st != SPC_IDLE |=> framing_error_flag)
    else $error("framing flag not set");
  ti_hold_a: assert property (@(posedge mclk) disable iff (!rst_b)
    sctl[B_TI] && !wr_sctl |=> sctl[B_TI])
    else $error("tx done cleared by hardware");
  ri_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    set_ri |=> sctl[B_RI])
    else $error("rx done not set");
  ti_set_a: assert property (@(posedge mclk) disable iff (!rst_b)
    set_ti |=> sctl[B_TI])
    else $error("tx done not set");
  top_view_a: assert property (@(posedge mclk) disable iff (!rst_b)
    (sfr_addr == SCTL_OFS) |-> sfr_rdata[7] == (framing_select ? framing_error_flag : mode_select_hi))
    else $error("bit 7 view wrong");
  rx_gate_a: assert property (@(posedge mclk) disable iff (!rst_b)
    rx_st == SPC_IDLE && !sctl[B_REN] |=> rx_st == SPC_IDLE)
    else $error("receiver started while disabled");
  slave_own_address_rst_a: assert property (@(posedge mclk)
    !rst_b |=> slave_own_address == 8'h00_00)
    else $error("own address not reset");
endmodule // spc_serial_port
`default_nettype wire

// File: spc_remote_uart.sv
// Remote UART model on the far side of the serial line
`timescale 1ns/100ps
`default_nettype none
module spc_remote_uart #(parameter int BIT_T = 64) (
  input wire logic mclk,
  input wire logic txd,
  output logic rxd
);
  logic [7:0] cap_byte;
  logic cap_ninth;
  logic cap_stop;
  int cap_cnt;
  // Bit period in clocks; the bench shortens it for the faster fixed rates
  int bit_t = BIT_T;
  initial begin
    rxd = 1'b1;
    cap_cnt = 0;
  end
  // Line idles at mark; a bad stop bit is sent when sb is low
  task automatic send(input logic [7:0] b, input logic nb, input logic sb);
    logic [10:0] f;
    f = {sb, nb, b, 1'b0};
    for (int i = 0; i < 11; i++) begin
      rxd = f[i];
      repeat (bit_t) @(negedge mclk);
    end
    rxd = 1'b1;
  endtask
  // Samples mid-bit, so a wrong bit period shows up as a corrupted frame
  initial begin
    forever begin
      @(negedge txd);
      repeat (bit_t / 2) @(posedge mclk);
      for (int i = 0; i < 10; i++) begin
        repeat (bit_t) @(posedge mclk);
        if (i < 8) cap_byte[i] = txd;
        else if (i == 8) cap_ninth = txd;
        else cap_stop = txd;
      end
      cap_cnt++;
    end
  end
endmodule // spc_remote_uart
`default_nettype wire

// File: serial_port_control_status_bench.sv
// Self-checking bench for the serial port control and status block
`timescale 1ns/100ps
`default_nettype none
module serial_port_control_status_bench;
  import spc_pkg::*;
  localparam int BIT_T = 64;
  logic mclk, rst_b, sfr_wr, tx_start, baud_tick, rxd_in, txd_out, dso, sclk, b9, hit_exp;
  logic [7:0] sfr_addr, sfr_wdata, tx_data, rx_data, addr_mask, sfr_rdata, d, sa, adr, g;
  logic [31:0] seed, bg;
  int errors, check_count, cycles, n, m, p, k, sclk_n;
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Own address under the mask, or every one bit of the address OR mask present
  function automatic logic hit(input logic [7:0] x, input logic [7:0] s, input logic [7:0] msk);
    return ((x & msk) == (s & msk)) || ((x & (s | msk)) == (s | msk));
  endfunction
  spc_serial_port uut (.mclk(mclk), .rst_b(rst_b), .sfr_addr(sfr_addr), .sfr_wdata(sfr_wdata),
    .sfr_wr(sfr_wr), .sfr_rdata(sfr_rdata), .tx_data(tx_data), .tx_start(tx_start),
    .rx_data(rx_data), .addr_mask(addr_mask), .double_speed_option(dso),
    .baud_tick(baud_tick), .rxd_in(rxd_in), .txd_out(txd_out), .shift_clk_out(sclk));
  spc_remote_uart #(.BIT_T(BIT_T)) prt (.mclk(mclk), .txd(txd_out), .rxd(rxd_in));
  initial begin
    mclk = 1'b0;
    forever #20 mclk = ~mclk;
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge mclk);
    sfr_addr = a;
    sfr_wdata = v;
    sfr_wr = 1'b1;
    @(negedge mclk);
    sfr_wr = 1'b0;
  endtask
  task automatic send_tx(input logic [7:0] v);
    @(negedge mclk);
    tx_data = v;
    tx_start = 1'b1;
    @(negedge mclk);
    tx_start = 1'b0;
  endtask
  always @(posedge sclk) sclk_n++;
  task automatic rd(input logic [7:0] a, input logic [7:0] msk, input logic [7:0] exp);
    @(negedge mclk);
    sfr_addr = a;
    #1 chk(sfr_rdata & msk, exp);
  endtask
  task automatic wrap_up;
    $display("checks=%0d errors=%0d", check_count, errors);
    if (errors == 0 && check_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  // Mode 2 ignores the bit-rate enable, so random ticks must not disturb it
  always @(negedge mclk) begin
    bg <= lfsr(bg);
    baud_tick <= bg[0];
    cycles++;
    if (cycles > 30000) begin
      errors++;
      wrap_up();
    end
  end
  initial begin
    seed = 32'h44de_270a;
    bg = ~seed;
    {rst_b, sfr_wr, tx_start, dso} = 4'h0;
    {sfr_addr, sfr_wdata, tx_data, addr_mask} = 32'h0000_0000;
    repeat (16) @(posedge mclk);
    @(negedge mclk);
    rst_b = 1'b1;
    rd(SCTL_OFS, 8'hff, SCTL_RST);
    rd(SLAVE_OWN_ADDRESS_OFS, 8'hff, SLAVE_OWN_ADDRESS_RST);
    rd(8'h55, 8'hff, 8'h00);
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      wr(SLAVE_OWN_ADDRESS_OFS, seed[7:0]);
      sa = seed[7:0];
      rd(SLAVE_OWN_ADDRESS_OFS, 8'hff, seed[7:0]);
    end
    wr(SCTL_OFS, 8'h80);
    rd(SCTL_OFS, 8'hff, 8'h80);
    wr(PCTL_OFS, 8'h40);
    rd(PCTL_OFS, 8'hff, 8'h40);
    rd(SCTL_OFS, 8'hff, 8'h00);
    for (n = 0; n < 4; n++) begin
      seed = lfsr(seed);
      wr(SCTL_OFS, 8'h10);
      prt.send(seed[7:0], seed[8], 1'b1);
      repeat (BIT_T) @(negedge mclk);
      chk(rx_data, seed[7:0]);
      rd(SCTL_OFS, 8'h05, {5'h00, seed[8], 2'h1});
    end
    prt.send(8'ha5, 1'b0, 1'b0);
    repeat (BIT_T) @(negedge mclk);
    rd(SCTL_OFS, 8'h80, 8'h80);
    prt.send(8'h5a, 1'b0, 1'b1);
    repeat (BIT_T) @(negedge mclk);
    rd(SCTL_OFS, 8'h80, 8'h80);
    wr(SCTL_OFS, 8'h00);
    d = rx_data;
    prt.send(8'h3c, 1'b1, 1'b1);
    repeat (BIT_T) @(negedge mclk);
    rd(SCTL_OFS, 8'h85, 8'h00);
    chk(rx_data, d);
    for (n = 0; n < 2; n++) begin
      seed = lfsr(seed);
      wr(SCTL_OFS, {4'h0, n[0], 3'h0});
      m = prt.cap_cnt;
      send_tx(seed[7:0]);
      repeat (12 * BIT_T) @(negedge mclk);
      chk(8'(prt.cap_cnt - m), 8'h01);
      chk(prt.cap_byte, seed[7:0]);
      chk({7'h00, prt.cap_ninth}, {7'h00, n[0]});
      chk({7'h00, prt.cap_stop}, 8'h01);
      rd(SCTL_OFS, 8'h02, 8'h02);
    end
    // Doubling and double speed shorten the fixed mode 2 bit; the partner follows
    for (n = 1; n < 4; n++) begin
      seed = lfsr(seed);
      p = (n == 3) ? 16 : 32;
      prt.bit_t = p;
      @(negedge mclk);
      dso = n[1];
      wr(PCTL_OFS, {n[0], 7'h40});
      wr(SCTL_OFS, 8'h18);
      prt.send(seed[7:0], seed[8], 1'b1);
      repeat (p) @(negedge mclk);
      chk(rx_data, seed[7:0]);
      rd(SCTL_OFS, 8'h05, {5'h00, seed[8], 2'h1});
      m = prt.cap_cnt;
      send_tx(seed[15:8]);
      repeat (12 * p) @(negedge mclk);
      chk(8'(prt.cap_cnt - m), 8'h01);
      chk(prt.cap_byte, seed[15:8]);
      chk({7'h00, prt.cap_ninth}, 8'h01);
    end
    dso = 1'b0;
    prt.bit_t = BIT_T;
    wr(PCTL_OFS, 8'h40);
    // Address frames: only own or broadcast addresses with the ninth bit set raise done
    for (n = 0; n < 6; n++) begin
      seed = lfsr(seed);
      adr = (n < 4) ? (n[0] ? 8'hff : sa) : seed[23:16];
      b9 = (n < 2) || (n > 3 && seed[24]);
      addr_mask = (n < 4) ? 8'hff : seed[15:8];
      wr(SCTL_OFS, 8'h30);
      d = rx_data;
      prt.send(adr, b9, 1'b1);
      repeat (BIT_T) @(negedge mclk);
      hit_exp = b9 && hit(adr, sa, addr_mask);
      rd(SCTL_OFS, 8'h01, {7'h00, hit_exp});
      chk(rx_data, hit_exp ? adr : d);
    end
    wr(SCTL_OFS, 8'h00);
    // Mode 0 shifts the byte out with its own clock, eight bits per transfer
    wr(PCTL_OFS, 8'h00);
    for (n = 0; n < 2; n++) begin
      seed = lfsr(seed);
      p = n[0] ? 6 : 12;
      dso = n[0];
      wr(SCTL_OFS, 8'h00);
      sclk_n = 0;
      send_tx(seed[7:0]);
      for (k = 0; k < 8; k++) begin
        g = {txd_out, g[7:1]};
        repeat (p) @(negedge mclk);
      end
      chk(g, seed[7:0]);
      chk(8'(sclk_n), 8'h08);
      rd(SCTL_OFS, 8'h02, 8'h02);
    end
    wr(SCTL_OFS, 8'h10);
    repeat (9 * p) @(negedge mclk);
    rd(SCTL_OFS, 8'h01, 8'h01);
    chk(rx_data, 8'hff);
    wrap_up();
  end
endmodule // serial_port_control_status_bench
`default_nettype wire
